// File: hw/ddh_params.svh
// Constants for the dual converter parallel host port controller
`ifndef DDH_PARAMS_SVH
`define DDH_PARAMS_SVH

// ------------------------------------------------------------------
// Data word layout
// ------------------------------------------------------------------
`define DDH_DATA_W        16
`define DDH_DATA_MSB      15
`define DDH_DATA_LSB      0
`define DDH_CODE_MID      16'h8000
`define DDH_CODE_ZERO     16'h0000

// ------------------------------------------------------------------
// Pin levels
// ------------------------------------------------------------------
`define DDH_SEL_A         1'b0
`define DDH_SEL_B         1'b1
`define DDH_RW_WRITE      1'b0
`define DDH_RW_READ       1'b1

// ------------------------------------------------------------------
// Timing in ns, rounded up to core clock cycles (20 ns each)
// ------------------------------------------------------------------
`define DDH_CLK_NS        20
`define DDH_SETUP_NS      40
`define DDH_PULSE_NS      60
`define DDH_HOLD_NS       40
`define DDH_CYC(ns)       ((((ns) + `DDH_CLK_NS - 1) / `DDH_CLK_NS) < 1 ? \
                           1 : (((ns) + `DDH_CLK_NS - 1) / `DDH_CLK_NS))
`define DDH_SETUP_CYC     `DDH_CYC(`DDH_SETUP_NS)
`define DDH_PULSE_CYC     `DDH_CYC(`DDH_PULSE_NS)
`define DDH_HOLD_CYC      `DDH_CYC(`DDH_HOLD_NS)
`define DDH_CNT_W         4

`endif

// File: hw/ddh_pkg.sv
// Types shared by the dual converter host port controller
package ddh_pkg;

    // --------------------------------------------------------------
    // Sequencer states
    // --------------------------------------------------------------
    typedef enum logic [5:0] {
        DDH_IDLE   = 6'b000001,
        DDH_SETUP  = 6'b000010,
        DDH_PULSE  = 6'b000100,
        DDH_HOLD   = 6'b001000,
        DDH_RDCAP  = 6'b010000,
        DDH_DONE   = 6'b100000
    } ddh_state_t;

    // --------------------------------------------------------------
    // Host request kinds
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        DDH_OP_WRITE  = 2'b00,
        DDH_OP_READ   = 2'b01,
        DDH_OP_UPDATE = 2'b10,
        DDH_OP_RESET  = 2'b11
    } ddh_op_t;

endpackage : ddh_pkg

// File: hw/ddh_seq_if.sv
// Interface between the controller core and its phase timer
`timescale 1ns/1ps
interface ddh_seq_if;
    logic       start;
    logic [3:0] len;
    logic       expired;

    modport core  (output start, output len, input expired);
    modport timer (input start, input len, output expired);
endinterface : ddh_seq_if

// File: hw/ddh_phase_timer.sv
// Down counter that times the setup, pulse and hold phases of a pin sequence
`timescale 1ns/1ps
`include "ddh_params.svh"
module ddh_phase_timer
    import ddh_pkg::*;
(
    input  wire logic core_clk,     // Core clock
    input  wire logic rst_b,        // Async reset, active low
    input  wire logic clk_en,       // Freezes the count when low
    ddh_seq_if.timer  seq           // Start, length, expiry
);

    logic [`DDH_CNT_W-1:0] cnt_r;
    logic [`DDH_CNT_W-1:0] cnt_nxt;
    logic                  exp_r;
    logic                  exp_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (seq.start) begin
            cnt_nxt = seq.len;
        end else if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
            exp_nxt = (cnt_r == 4'h1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 4'h0;
            exp_r <= 1'b0;
        end else if (clk_en) begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign seq.expired = exp_r;

endmodule : ddh_phase_timer

// File: hw/ddh_host_ctrl.sv
// Host side controller driving the dual converter parallel port
`timescale 1ns/1ps
`include "ddh_params.svh"

// What this block does
// - Drive all sixteen code bits together
// - Chip select active low for accesses
// - Read/write matters only under chip select
// - Channel select low is A, high B
module ddh_host_ctrl
    import ddh_pkg::*;
(
    input  wire logic        core_clk,      // Core clock, 50 MHz
    input  wire logic        rst_b,         // Async reset, active low
    input  wire logic        clk_en,        // Freezes state when low
    input  wire logic        req_valid,     // Request strobe
    input  wire logic [1:0]  req_op,        // Request kind
    input  wire logic        req_chan,      // Channel, 0 is A
    input  wire logic [15:0] req_data,      // Code to write
    output logic             req_ready,     // Idle, may take request
    output logic             rsp_valid,     // One-cycle completion
    output logic [15:0]      rsp_data,      // Read back code
    output logic [15:0]      data_bus_drv,  // Data bus drive value
    output logic             data_bus_oe,   // High while driving bus
    input  wire logic [15:0] data_bus_smp,  // Data bus level seen
    output logic             chip_sel_b,    // Chip select, active low
    output logic             rd_wr,         // High read, low write
    output logic             channel_select,// Low A, high B
    output logic             output_update_strobe, // Load strobe
    output logic             reset_pin      // Reset, rising edge
);

    ddh_seq_if seq ();

    ddh_phase_timer u_timer (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .seq      (seq.timer)
    );

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    ddh_state_t  st_r,   st_nxt;
    ddh_op_t     op_r,   op_nxt;
    logic        chan_r, chan_nxt;
    logic [15:0] wdat_r, wdat_nxt;
    logic        rdy_r,  rdy_nxt;
    logic        rv_r,   rv_nxt;
    logic [15:0] rd_r,   rd_nxt;
    logic [15:0] dbo_r,  dbo_nxt;
    logic        oe_r,   oe_nxt;
    logic        cs_r,   cs_nxt;
    logic        rw_r,   rw_nxt;
    logic        sel_r,  sel_nxt;
    logic        upd_r,  upd_nxt;
    logic        rst_r,  rst_nxt;
    logic        tstart;
    logic [3:0]  tlen;

    function automatic logic is_access(input ddh_op_t op);
        return (op == DDH_OP_WRITE) || (op == DDH_OP_READ);
    endfunction : is_access

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always_comb begin
        st_nxt   = st_r;
        op_nxt   = op_r;
        chan_nxt = chan_r;
        wdat_nxt = wdat_r;
        rdy_nxt  = rdy_r;
        rv_nxt   = 1'b0;
        rd_nxt   = rd_r;
        dbo_nxt  = dbo_r;
        oe_nxt   = oe_r;
        cs_nxt   = cs_r;
        rw_nxt   = rw_r;
        sel_nxt  = sel_r;
        upd_nxt  = upd_r;
        rst_nxt  = rst_r;
        tstart   = 1'b0;
        tlen     = 4'h0;
        case (st_r)
            DDH_IDLE: begin
                if (req_valid) begin
                    op_nxt   = ddh_op_t'(req_op);
                    chan_nxt = req_chan;
                    wdat_nxt = req_data;
                    rdy_nxt  = 1'b0;
                    // Address pins settle before any strobe edge
                    sel_nxt  = req_chan;
                    rw_nxt   = (ddh_op_t'(req_op) == DDH_OP_READ)
                             ? `DDH_RW_READ : `DDH_RW_WRITE;
                    if (ddh_op_t'(req_op) == DDH_OP_WRITE) begin
                        dbo_nxt = req_data;
                        oe_nxt  = 1'b1;
                    end
                    tstart = 1'b1;
                    tlen   = 4'(`DDH_SETUP_CYC);
                    st_nxt = DDH_SETUP;
                end
            end
            DDH_SETUP: begin
                if (seq.expired) begin
                    if (is_access(op_r)) begin
                        cs_nxt = 1'b0;
                    end else if (op_r == DDH_OP_UPDATE) begin
                        upd_nxt = 1'b1;
                    end else begin
                        rst_nxt = 1'b1;
                    end
                    tstart = 1'b1;
                    tlen   = 4'(`DDH_PULSE_CYC);
                    st_nxt = DDH_PULSE;
                end
            end
            DDH_PULSE: begin
                if (seq.expired) begin
                    st_nxt = (op_r == DDH_OP_READ) ? DDH_RDCAP : DDH_HOLD;
                    if (op_r != DDH_OP_READ) begin
                        // Rising chip select ends the write cleanly
                        cs_nxt  = 1'b1;
                        upd_nxt = 1'b0;
                        rst_nxt = 1'b0;
                        tstart  = 1'b1;
                        tlen    = 4'(`DDH_HOLD_CYC);
                    end
                end
            end
            DDH_RDCAP: begin
                rd_nxt = data_bus_smp;
                cs_nxt = 1'b1;
                tstart = 1'b1;
                tlen   = 4'(`DDH_HOLD_CYC);
                st_nxt = DDH_HOLD;
            end
            DDH_HOLD: begin
                if (seq.expired) begin
                    oe_nxt = 1'b0;
                    rw_nxt = `DDH_RW_READ;
                    st_nxt = DDH_DONE;
                end
            end
            DDH_DONE: begin
                rv_nxt  = 1'b1;
                rdy_nxt = 1'b1;
                st_nxt  = DDH_IDLE;
            end
            default: begin
                st_nxt = DDH_IDLE;
            end
        endcase
    end

    assign seq.start = tstart;
    assign seq.len   = tlen;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r   <= DDH_IDLE;
            op_r   <= DDH_OP_WRITE;
            chan_r <= 1'b0;
            wdat_r <= 16'h0000;
            rdy_r  <= 1'b1;
            rv_r   <= 1'b0;
            rd_r   <= 16'h0000;
            dbo_r  <= 16'h0000;
            oe_r   <= 1'b0;
            cs_r   <= 1'b1;
            rw_r   <= 1'b1;
            sel_r  <= 1'b0;
            upd_r  <= 1'b0;
            rst_r  <= 1'b0;
        end else if (clk_en) begin
            st_r   <= st_nxt;
            op_r   <= op_nxt;
            chan_r <= chan_nxt;
            wdat_r <= wdat_nxt;
            rdy_r  <= rdy_nxt;
            rv_r   <= rv_nxt;
            rd_r   <= rd_nxt;
            dbo_r  <= dbo_nxt;
            oe_r   <= oe_nxt;
            cs_r   <= cs_nxt;
            rw_r   <= rw_nxt;
            sel_r  <= sel_nxt;
            upd_r  <= upd_nxt;
            rst_r  <= rst_nxt;
        end
    end

    assign req_ready            = rdy_r;
    assign rsp_valid            = rv_r;
    assign rsp_data             = rd_r;
    assign data_bus_drv         = dbo_r;
    assign data_bus_oe          = oe_r;
    assign chip_sel_b           = cs_r;
    assign rd_wr                = rw_r;
    assign channel_select       = sel_r;
    assign output_update_strobe = upd_r;
    assign reset_pin            = rst_r;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    chk_no_bus_fight: assert property (@(posedge core_clk) disable iff (!rst_b)
        !(data_bus_oe && !chip_sel_b && rd_wr))
        else $error("host drives bus during read");
    chk_write_data_full: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        $fell(chip_sel_b) && !rd_wr |-> data_bus_oe)
        else $error("write without driven data");
    chk_sel_stable_cs: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !chip_sel_b && !$rose(chip_sel_b) |-> $stable(channel_select))
        else $error("channel select moved under chip select");
    chk_rw_stable_cs: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !chip_sel_b |-> $stable(rd_wr))
        else $error("read/write moved under chip select");
    chk_strobe_excl: assert property (@(posedge core_clk) disable iff (!rst_b)
        !(output_update_strobe && !chip_sel_b))
        else $error("update strobe during access");
    chk_reset_excl: assert property (@(posedge core_clk) disable iff (!rst_b)
        reset_pin |-> chip_sel_b && !output_update_strobe)
        else $error("reset pulse overlaps other strobe");
    chk_pulse_width: assert property (@(posedge core_clk)
        disable iff (!rst_b || !clk_en)
        $rose(output_update_strobe) |-> output_update_strobe[*3])
        else $error("update strobe too short");
    chk_read_resp: assert property (@(posedge core_clk)
        disable iff (!rst_b || !clk_en)
        $fell(chip_sel_b) && rd_wr |-> ##[5:12] rsp_valid)
        else $error("read response missing");

endmodule : ddh_host_ctrl

// File: bench/ddh_dev_model.sv
// Behavioural model of the dual converter's digital port
`timescale 1ns/1ps
module ddh_dev_model #(
    parameter logic [15:0] RESET_CODE = 16'h8000 // Variant reset code
) (
    input  wire logic        chip_sel_b,           // Chip select, low
    input  wire logic        rd_wr,                // High read, low write
    input  wire logic        channel_select,       // Low A, high B
    input  wire logic        output_update_strobe, // Update on rise
    input  wire logic        reset_pin,            // Reset on rise
    input  wire logic [15:0] bus,                  // Resolved data bus
    output logic      [15:0] drive,                // Read back value
    output logic             drive_oe,             // High while reading
    output logic      [15:0] dac_a,                // Channel A output code
    output logic      [15:0] dac_b                 // Channel B output code
);
    logic [15:0] in_a;
    logic [15:0] in_b;

    // Capture on the closing edge, so a slow bus settles first
    always @(posedge chip_sel_b) begin
        if (rd_wr === 1'b0) begin
            if (channel_select === 1'b0) begin
                in_a <= bus;
            end else if (channel_select === 1'b1) begin
                in_b <= bus;
            end
        end
    end

    always @(posedge output_update_strobe) begin
        dac_a <= in_a;
        dac_b <= in_b;
    end

    always @(posedge reset_pin) begin
        in_a  <= RESET_CODE;
        in_b  <= RESET_CODE;
        dac_a <= RESET_CODE;
        dac_b <= RESET_CODE;
    end

    assign drive_oe = (chip_sel_b === 1'b0) && (rd_wr === 1'b1);
    assign drive    = channel_select ? in_b : in_a;
endmodule : ddh_dev_model

// File: bench/tb.sv
// Self-checking bench for the dual converter host port controller
`timescale 1ns/1ps
module tb;
    import ddh_pkg::*;
    localparam logic [15:0] RC = 16'h8000;
    logic        core_clk, rst_b, clk_en, req_valid, req_chan, req_ready;
    logic        rsp_valid, host_oe, chip_sel_b, rd_wr, channel_select;
    logic        output_update_strobe, reset_pin, dev_oe;
    logic [1:0]  req_op;
    logic [15:0] req_data, rsp_data, host_o, bus, dev_o, last_v;
    logic [15:0] dac_a, dac_b;
    int          fails, checked;

    ddh_host_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .clk_en(clk_en), .req_valid(req_valid), .req_op(req_op),
        .req_chan(req_chan), .req_data(req_data), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .data_bus_drv(host_o),
        .data_bus_oe(host_oe), .data_bus_smp(bus), .chip_sel_b(chip_sel_b),
        .rd_wr(rd_wr), .channel_select(channel_select),
        .output_update_strobe(output_update_strobe), .reset_pin(reset_pin));

    ddh_dev_model #(.RESET_CODE(RC)) i_dev (.chip_sel_b(chip_sel_b),
        .rd_wr(rd_wr), .channel_select(channel_select),
        .output_update_strobe(output_update_strobe), .reset_pin(reset_pin),
        .bus(bus), .drive(dev_o), .drive_oe(dev_oe), .dac_a(dac_a),
        .dac_b(dac_b));

    // Undriven bus shows the inverse of its last value, never a lucky match
    assign bus = host_oe ? host_o : (dev_oe ? dev_o : ~last_v);
    always @(posedge core_clk) if (host_oe | dev_oe) last_v <= bus;
    always #10 core_clk = ~core_clk;

    always @(negedge core_clk) begin
        if (host_oe === 1'b1 && dev_oe === 1'b1) begin
            fails++;
            $display("wrong value at %0t: bus driven by both", $time);
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // Junk mode freezes four edges, then offers a request while busy
    // for three enabled edges; the busy controller must ignore it
    task automatic run_op(input ddh_op_t op, input logic ch,
                          input logic [15:0] d, input int lat, input bit junk);
        int n;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_op = op;
        req_chan = ch;
        req_data = d;
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 1;
        if (junk) begin
            clk_en = 1'b0;
            req_valid = 1'b1;
            req_op = DDH_OP_WRITE;
            req_chan = 1'b0;
            req_data = 16'hDEAD;
        end
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
            if (n == 5) begin
                clk_en = 1'b1;
            end
            if (n == 8) begin
                req_valid = 1'b0;
            end
        end
        chk(16'(n - 1), 16'(lat), "latency");
    endtask : run_op

    task automatic rd(input logic ch, input logic [15:0] exp);
        run_op(DDH_OP_READ, ch, 16'h0000, 12, 1'b0);
        chk(rsp_data, exp, "readback");
    endtask : rd

    task automatic t_idle();
        chk({10'h000, chip_sel_b, rd_wr, host_oe, output_update_strobe,
             reset_pin, req_ready}, 16'h0031, "idle pins");
        $display("test idle done");
    endtask : t_idle

    task automatic t_dev_reset();
        run_op(DDH_OP_RESET, 1'b0, 16'h0000, 11, 1'b0);
        chk(dac_a, RC, "dac a");
        chk(dac_b, RC, "dac b");
        rd(1'b0, RC);
        rd(1'b1, RC);
        $display("test device reset done");
    endtask : t_dev_reset

    task automatic t_stage();
        run_op(DDH_OP_WRITE, 1'b0, 16'h8001, 11, 1'b0);
        run_op(DDH_OP_WRITE, 1'b1, 16'h7FFE, 11, 1'b0);
        rd(1'b0, 16'h8001);
        rd(1'b1, 16'h7FFE);
        chk(dac_a, RC, "dac a held");
        chk(dac_b, RC, "dac b held");
        $display("test staging done");
    endtask : t_stage

    task automatic t_update();
        run_op(DDH_OP_UPDATE, 1'b0, 16'h0000, 11, 1'b0);
        chk(dac_a, 16'h8001, "dac a");
        chk(dac_b, 16'h7FFE, "dac b");
        rd(1'b0, 16'h8001);
        $display("test update done");
    endtask : t_update

    task automatic t_refuse_freeze();
        run_op(DDH_OP_WRITE, 1'b1, 16'h5A5A, 15, 1'b1);
        rd(1'b1, 16'h5A5A);
        rd(1'b0, 16'h8001);
        chk(dac_b, 16'h7FFE, "dac b held");
        $display("test refuse and freeze done");
    endtask : t_refuse_freeze

    task automatic t_reset_all();
        run_op(DDH_OP_RESET, 1'b0, 16'h0000, 11, 1'b0);
        chk(dac_a, RC, "dac a");
        chk(dac_b, RC, "dac b");
        rd(1'b0, RC);
        rd(1'b1, RC);
        $display("test full reset done");
    endtask : t_reset_all

    task automatic close_out();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req_op = 2'h0;
        req_chan = 1'b0;
        req_data = 16'h0000;
        last_v = 16'h0000;
        fails = 0;
        checked = 0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        t_idle();
        t_dev_reset();
        t_stage();
        t_update();
        t_refuse_freeze();
        t_reset_all();
        close_out();
    end

    // Whole run needs under 300 cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        fails++;
        $display("wrong value at %0t: watchdog expired", $time);
        close_out();
    end
endmodule : tb
